/* File: hw/mem_mode_cfg.sv */
// Memory map decode and start-up mode selection of the core.
// Assumes an APB master on clk and same-clock core request signals.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mem_mode_cfg (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode pins
    input  wire logic        mode_pin_a,
    input  wire logic        mode_pin_b,
    input  wire logic        mode_pin_c,
    input  wire logic        mode_pin_d,
    // Core address lookup
    input  wire logic        acc_valid,
    input  wire logic [1:0]  acc_space,
    input  wire logic [23:0] acc_addr,
    output logic             dec_valid,
    output logic             dec_ram,
    output logic             dec_cache,
    output logic             dec_io,
    output logic             dec_ext,
    // Start-up control
    input  wire logic        boot_jump,
    output logic             boot_go,
    output logic             boot_deny,
    output logic      [1:0]  boot_variant,
    output logic      [23:0] reset_vector,
    output logic             mode_ready,
    // Configuration state
    output logic             sixteen_bit_compat,
    output logic             cache_enable,
    output logic             memory_switch
);
    // ----------------------------------------
    // Reset release and pin capture
    // ----------------------------------------
    logic [1:0] rst_q_r;
    logic       rst_n_s;
    logic [3:0] pins_s;
    logic       mode_ready_r;
    logic [3:0] mode_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q_r <= 2'h0;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'h1};
        end
    end
    assign rst_n_s = rst_q_r[1];

    pin_sync #(.W(4)) u_pins (
        .clk          (clk),
        .pin_in       ({mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a}),
        .pin_sync_out (pins_s)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_nxt;
    logic        compat_r;
    logic        cache_en_r;
    logic        switch_r;
    logic [3:0]  prog_k;
    logic [3:0]  data_k;
    logic [23:0] vec_nxt;
    logic [1:0]  var_nxt;
    logic        reserved;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign mapped = paddr == core_cfg_pkg::OFF_STATUS
                 || paddr == core_cfg_pkg::OFF_OPMODE
                 || paddr == core_cfg_pkg::OFF_MAPINFO
                 || paddr == core_cfg_pkg::OFF_BOOT;

    always_comb begin
        rd_nxt = 32'h0;
        unique case (paddr)
            core_cfg_pkg::OFF_STATUS: begin
                rd_nxt[core_cfg_pkg::STAT_COMPAT_BIT] = compat_r;
                rd_nxt[core_cfg_pkg::STAT_CACHE_BIT]  = cache_en_r;
            end
            core_cfg_pkg::OFF_OPMODE: begin
                rd_nxt[3:0] = mode_r;
                rd_nxt[core_cfg_pkg::OPM_SWITCH_BIT] = switch_r;
            end
            core_cfg_pkg::OFF_MAPINFO: begin
                rd_nxt[3:0]   = prog_k;
                rd_nxt[7:4]   = data_k;
                rd_nxt[11:8]  = data_k;
                rd_nxt[12]    = cache_en_r;
                rd_nxt[13]    = compat_r;
            end
            core_cfg_pkg::OFF_BOOT: begin
                rd_nxt[23:0]  = vec_nxt;
                rd_nxt[25:24] = var_nxt;
                rd_nxt[26]    = reserved;
                rd_nxt[27]    = mode_ready_r;
            end
            default: rd_nxt = 32'h0;
        endcase
    end

    // No wait state: data is captured in the setup cycle
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= setup && !pwrite ? rd_nxt : 32'h0;
        end
    end

    // ----------------------------------------
    // Configuration bits
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            compat_r   <= core_cfg_pkg::COMPAT_RST;
            cache_en_r <= core_cfg_pkg::CACHE_RST;
        end else if (wr_en && paddr == core_cfg_pkg::OFF_STATUS) begin
            if (pstrb[1]) begin
                compat_r <= pwdata[core_cfg_pkg::STAT_COMPAT_BIT];
            end
            if (pstrb[2]) begin
                cache_en_r <= pwdata[core_cfg_pkg::STAT_CACHE_BIT];
            end
        end
    end

    // Not blocked while the cache is on; software orders the change
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            switch_r <= core_cfg_pkg::SWITCH_RST;
        end else if (wr_en && paddr == core_cfg_pkg::OFF_OPMODE
                     && pstrb[0]) begin
            switch_r <= pwdata[core_cfg_pkg::OPM_SWITCH_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            mode_r       <= core_cfg_pkg::MODE_RST;
            mode_ready_r <= 1'h0;
        end else if (!mode_ready_r) begin
            mode_r       <= pins_s;
            mode_ready_r <= 1'h1;
        end else if (wr_en && paddr == core_cfg_pkg::OFF_OPMODE
                     && pstrb[0]) begin
            mode_r <= pwdata[3:0];
        end
    end

    // ----------------------------------------
    // Layout selection
    // ----------------------------------------
    logic [23:0] prog_end;
    logic [23:0] cache_base;
    logic [23:0] cache_end;
    logic [23:0] data_end;
    logic [23:0] io_base;

    always_comb begin
        unique case ({switch_r, cache_en_r})
            2'h0: prog_end = core_cfg_pkg::PROG_END_DEF;
            2'h1: prog_end = core_cfg_pkg::PROG_END_CACHE;
            2'h2: prog_end = core_cfg_pkg::PROG_END_SW;
            default: prog_end = core_cfg_pkg::PROG_END_SWC;
        endcase
        prog_k     = switch_r ? (cache_en_r ? 4'h1 : 4'h2)
                              : (cache_en_r ? 4'h3 : 4'h4);
        data_k     = switch_r ? 4'h3 : 4'h2;
        cache_base = switch_r ? core_cfg_pkg::CACHE_BASE_SW
                              : core_cfg_pkg::CACHE_BASE_DEF;
        cache_end  = switch_r ? core_cfg_pkg::CACHE_END_SW
                              : core_cfg_pkg::CACHE_END_DEF;
        data_end   = switch_r ? core_cfg_pkg::DATA_END_SW
                              : core_cfg_pkg::DATA_END_DEF;
        io_base    = compat_r ? core_cfg_pkg::IO_BASE_16
                              : core_cfg_pkg::IO_BASE_24;
    end

    // ----------------------------------------
    // Per-space lookup
    // ----------------------------------------
    logic [3:0] hit_p;
    logic [3:0] hit_x;
    logic [3:0] hit_y;
    logic [3:0] hit_sel;

    space_decode #(.AW(24)) u_p (
        .addr(acc_addr), .narrow(compat_r), .ram_end(prog_end),
        .cache_en(cache_en_r), .cache_base(cache_base),
        .cache_end(cache_end), .io_en(1'h0), .io_base(io_base),
        .hit_ram(hit_p[0]), .hit_cache(hit_p[1]),
        .hit_io(hit_p[2]), .hit_ext(hit_p[3])
    );
    space_decode #(.AW(24)) u_x (
        .addr(acc_addr), .narrow(compat_r), .ram_end(data_end),
        .cache_en(1'h0), .cache_base(cache_base),
        .cache_end(cache_end), .io_en(1'h1), .io_base(io_base),
        .hit_ram(hit_x[0]), .hit_cache(hit_x[1]),
        .hit_io(hit_x[2]), .hit_ext(hit_x[3])
    );
    space_decode #(.AW(24)) u_y (
        .addr(acc_addr), .narrow(compat_r), .ram_end(data_end),
        .cache_en(1'h0), .cache_base(cache_base),
        .cache_end(cache_end), .io_en(1'h0), .io_base(io_base),
        .hit_ram(hit_y[0]), .hit_cache(hit_y[1]),
        .hit_io(hit_y[2]), .hit_ext(hit_y[3])
    );

    always_comb begin
        unique case (acc_space)
            core_cfg_pkg::SPACE_P: hit_sel = hit_p;
            core_cfg_pkg::SPACE_X: hit_sel = hit_x;
            core_cfg_pkg::SPACE_Y: hit_sel = hit_y;
            default: hit_sel = 4'h8;
        endcase
    end

    // Live config every cycle, so a change applies to the next lookup
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            dec_valid <= 1'h0;
            {dec_ext, dec_io, dec_cache, dec_ram} <= 4'h0;
        end else begin
            dec_valid <= acc_valid;
            {dec_ext, dec_io, dec_cache, dec_ram} <=
                acc_valid ? hit_sel : 4'h0;
        end
    end

    // ----------------------------------------
    // Start-up vector and bootstrap launch
    // ----------------------------------------
    logic boot_ok;

    always_comb begin
        reserved = mode_r[2:0] == 3'h3;
        unique case (mode_r[2:0])
            3'h0: var_nxt = core_cfg_pkg::BOOT_NONE;
            3'h1: var_nxt = core_cfg_pkg::BOOT_BYTEMEM;
            3'h2: var_nxt = core_cfg_pkg::BOOT_SERIAL;
            3'h3: var_nxt = core_cfg_pkg::BOOT_NONE;
            default: var_nxt = core_cfg_pkg::BOOT_HOST;
        endcase
        if (mode_r == 4'h0) begin
            vec_nxt = core_cfg_pkg::VEC_EXPANDED0;
        end else if (mode_r == 4'h8) begin
            vec_nxt = core_cfg_pkg::VEC_EXPANDED8;
        end else begin
            vec_nxt = core_cfg_pkg::VEC_BOOT;
        end
        boot_ok = mode_r[2:0] != 3'h0 && !reserved;
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            reset_vector <= core_cfg_pkg::VEC_EXPANDED0;
            boot_variant <= core_cfg_pkg::BOOT_NONE;
            boot_go      <= 1'h0;
            boot_deny    <= 1'h0;
        end else begin
            reset_vector <= vec_nxt;
            boot_variant <= var_nxt;
            boot_go      <= boot_jump && boot_ok;
            boot_deny    <= boot_jump && !boot_ok;
        end
    end

    assign mode_ready         = mode_ready_r;
    assign sixteen_bit_compat = compat_r;
    assign cache_enable       = cache_en_r;
    assign memory_switch      = switch_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    sequence s_lookup_p(logic [23:0] a);
        acc_valid && acc_space == core_cfg_pkg::SPACE_P && acc_addr == a;
    endsequence
    sequence s_jump_ok;
        boot_jump && mode_r[2:0] != 3'h0 && mode_r[2:0] != 3'h3;
    endsequence

    property p_default_map;
        !compat_r && !switch_r && !cache_en_r ##0 s_lookup_p(24'h000fff)
        |=> dec_ram && !dec_cache && !dec_ext;
    endproperty
    property p_cache_map;
        !switch_r && cache_en_r ##0 s_lookup_p(24'h000c00)
        |=> dec_cache && !dec_ram;
    endproperty
    property p_switch_data;
        switch_r && acc_valid && acc_space == core_cfg_pkg::SPACE_X
        && acc_addr == 24'h000bff |=> dec_ram;
    endproperty
    property p_switch_cache;
        switch_r && cache_en_r ##0 s_lookup_p(24'h000400)
        |=> dec_cache && !dec_ram;
    endproperty
    property p_compat_wrap;
        compat_r && !switch_r && !cache_en_r ##0 s_lookup_p(24'h010000)
        |=> dec_ram;
    endproperty
    property p_io_top;
        acc_valid && acc_space == core_cfg_pkg::SPACE_X
        && acc_addr == 24'hffff80 && !compat_r |=> dec_io && !dec_ext;
    endproperty
    property p_external;
        switch_r && !cache_en_r ##0 s_lookup_p(24'h000800)
        |=> dec_ext && !dec_ram;
    endproperty
    property p_mode_latch;
        !mode_ready_r |=> mode_ready_r && mode_r == $past(pins_s);
    endproperty
    property p_boot_go;
        s_jump_ok |=> boot_go && !boot_deny;
    endproperty
    property p_boot_deny;
        boot_jump && mode_r[2:0] == 3'h0 |=> boot_deny && !boot_go;
    endproperty
    property p_vec0;
        mode_r == 4'h0 ##1 mode_r == 4'h0 |-> reset_vector == 24'hc00000;
    endproperty
    property p_vec8;
        mode_r == 4'h8 |=> reset_vector == 24'h008000;
    endproperty
    property p_vec_boot;
        mode_r[2:0] == 3'h5 |=> reset_vector == 24'hff0000
                                && boot_variant == 2'h3;
    endproperty

    a_default_map: assert property (p_default_map)
        else $error("default layout lookup wrong");
    a_cache_map: assert property (p_cache_map)
        else $error("cache window not at C00");
    a_switch_data: assert property (p_switch_data)
        else $error("switched data RAM not 3K");
    a_switch_cache: assert property (p_switch_cache)
        else $error("switched cache not at 400");
    a_compat_wrap: assert property (p_compat_wrap)
        else $error("16-bit space did not drop upper bits");
    a_io_top: assert property (p_io_top)
        else $error("X I/O space not decoded");
    a_external: assert property (p_external)
        else $error("address beyond RAM not external");
    a_mode_latch: assert property (p_mode_latch)
        else $error("mode bits not taken from pins at release");
    a_boot_go: assert property (p_boot_go)
        else $error("bootstrap not launched");
    a_boot_deny: assert property (p_boot_deny)
        else $error("mode 0 or 8 launched bootstrap");
    a_vec0: assert property (p_vec0)
        else $error("mode 0 vector wrong");
    a_vec8: assert property (p_vec8)
        else $error("mode 8 vector wrong");
    a_vec_boot: assert property (p_vec_boot)
        else $error("boot mode vector wrong");
endmodule // mem_mode_cfg
`default_nettype wire

/* File: hw/core_cfg_pkg.sv */
// Constants for the memory map and start-up mode decode block.
// Assumes a 24-bit core address and a 32-bit APB register port.
package core_cfg_pkg;
    // ----------------------------------------
    // Register offsets and fields
    // ----------------------------------------
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_OPMODE  = 8'h04;
    localparam logic [7:0] OFF_MAPINFO = 8'h08;
    localparam logic [7:0] OFF_BOOT    = 8'h0c;
    localparam int STAT_COMPAT_BIT = 13;
    localparam int STAT_CACHE_BIT  = 19;
    localparam int OPM_SWITCH_BIT  = 7;
    localparam logic       COMPAT_RST = 1'h0;
    localparam logic       CACHE_RST  = 1'h0;
    localparam logic       SWITCH_RST = 1'h0;
    localparam logic [3:0] MODE_RST   = 4'h0;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] MASK_16        = 24'h00ffff;
    localparam logic [23:0] PROG_END_DEF   = 24'h000fff;
    localparam logic [23:0] PROG_END_CACHE = 24'h000bff;
    localparam logic [23:0] PROG_END_SW    = 24'h0007ff;
    localparam logic [23:0] PROG_END_SWC   = 24'h0003ff;
    localparam logic [23:0] CACHE_BASE_DEF = 24'h000c00;
    localparam logic [23:0] CACHE_END_DEF  = 24'h000fff;
    localparam logic [23:0] CACHE_BASE_SW  = 24'h000400;
    localparam logic [23:0] CACHE_END_SW   = 24'h0007ff;
    localparam logic [23:0] DATA_END_DEF   = 24'h0007ff;
    localparam logic [23:0] DATA_END_SW    = 24'h000bff;
    localparam logic [23:0] IO_BASE_24     = 24'hffff80;
    localparam logic [23:0] IO_BASE_16     = 24'h00ff80;
    // ----------------------------------------
    // Start-up vectors and variants
    // ----------------------------------------
    localparam logic [23:0] VEC_EXPANDED0 = 24'hc00000;
    localparam logic [23:0] VEC_EXPANDED8 = 24'h008000;
    localparam logic [23:0] VEC_BOOT      = 24'hff0000;
    localparam logic [1:0] BOOT_NONE    = 2'h0;
    localparam logic [1:0] BOOT_BYTEMEM = 2'h1;
    localparam logic [1:0] BOOT_SERIAL  = 2'h2;
    localparam logic [1:0] BOOT_HOST    = 2'h3;
    localparam logic [1:0] SPACE_P = 2'h0;
    localparam logic [1:0] SPACE_X = 2'h1;
    localparam logic [1:0] SPACE_Y = 2'h2;
endpackage

/* File: hw/pin_sync.sv */
// Two-stage synchroniser for a group of slow pins.
// Assumes the pins are quasi-static; bits are not aligned to each other.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 4
) (
    // Clock
    input  wire logic         clk,
    // Pins and synchronised copy
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);
    logic [W-1:0] meta_r;

    if (W < 1) begin : g_bad_w
        $error("pin_sync: W must be at least 1");
    end

    // No reset: runs through reset so the pins are valid at release
    always_ff @(posedge clk) begin
        meta_r       <= pin_in;
        pin_sync_out <= meta_r;
    end
endmodule // pin_sync
`default_nettype wire

/* File: hw/space_decode.sv */
// Range check of one memory space against the active on-chip layout.
// Assumes the limits are stable in the cycle of the lookup.
`timescale 1ns/1ps
`default_nettype none
module space_decode #(
    parameter int AW = 24
) (
    // Lookup
    input  wire logic [AW-1:0] addr,
    input  wire logic          narrow,
    // Layout
    input  wire logic [AW-1:0] ram_end,
    input  wire logic          cache_en,
    input  wire logic [AW-1:0] cache_base,
    input  wire logic [AW-1:0] cache_end,
    input  wire logic          io_en,
    input  wire logic [AW-1:0] io_base,
    // Result
    output logic               hit_ram,
    output logic               hit_cache,
    output logic               hit_io,
    output logic               hit_ext
);
    logic [AW-1:0] eff;

    if (AW != core_cfg_pkg::ADDR_W) begin : g_bad_aw
        $error("space_decode: AW must match the core address width");
    end

    always_comb begin
        // Upper bits are dropped in the 16-bit space
        eff       = narrow ? (addr & core_cfg_pkg::MASK_16) : addr;
        hit_ram   = eff <= ram_end;
        hit_cache = cache_en && eff >= cache_base && eff <= cache_end;
        hit_io    = io_en && eff >= io_base;
        hit_ext   = !(hit_ram || hit_cache || hit_io);
    end
endmodule // space_decode
`default_nettype wire

/* File: verif/mode_strap.sv */
// Board strap model driving the four start-up mode pins.
// Assumes the bench changes the code only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module mode_strap (
    // Clock and strap code
    input  wire logic       clk,
    input  wire logic [3:0] code,
    // Mode pins
    output logic            mode_pin_a,
    output logic            mode_pin_b,
    output logic            mode_pin_c,
    output logic            mode_pin_d
);
    // Clocked so the straps never glitch around reset release
    always_ff @(posedge clk) begin
        {mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a} <= code;
    end
endmodule // mode_strap
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the memory map and start-up mode block.
// Assumes the strap model in mode_strap.sv and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, nrst = 1'b0, err;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, code = 4'h8;
    logic        pready, pslverr, acc_valid = 1'b0, boot_jump = 1'b0;
    logic [1:0]  acc_space = 2'h0, boot_variant;
    logic [23:0] acc_addr = 24'h0, reset_vector;
    logic        mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d;
    logic        dec_valid, dec_ram, dec_cache, dec_io, dec_ext;
    logic        boot_go, boot_deny, mode_ready;
    logic        sixteen_bit_compat, cache_enable, memory_switch;
    int          fail_count = 0, tests_run = 0;

    mem_mode_cfg uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .mode_pin_a,
        .mode_pin_b, .mode_pin_c, .mode_pin_d, .acc_valid, .acc_space,
        .acc_addr, .dec_valid, .dec_ram, .dec_cache, .dec_io, .dec_ext,
        .boot_jump, .boot_go, .boot_deny, .boot_variant, .reset_vector,
        .mode_ready, .sixteen_bit_compat, .cache_enable, .memory_switch);
    mode_strap board (.clk, .code, .mode_pin_a, .mode_pin_b,
        .mode_pin_c, .mode_pin_d);

    initial begin
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic rdy = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !rdy; i++) begin
            @(posedge clk);
            rdy = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!rdy) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic look(input logic [1:0] s, input logic [23:0] a,
                        input logic [3:0] e);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_space <= s;
        acc_addr <= a;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1 chk({dec_valid, dec_ram, dec_cache, dec_io, dec_ext}, {1'b1, e});
    endtask

    task automatic jump(input logic [1:0] e);
        @(posedge clk);
        boot_jump <= 1'b1;
        @(posedge clk);
        boot_jump <= 1'b0;
        #1 chk({boot_go, boot_deny}, e);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_reset(input logic [3:0] c, input logic [23:0] v,
                            input logic [1:0] bv);
        @(posedge clk);
        nrst <= 1'b0;
        code <= c;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk(mode_ready, 1'b1);
        chk(reset_vector, v);
        chk(boot_variant, bv);
    endtask

    task automatic modes();
        logic [23:0] v;
        logic [1:0]  bv;
        logic        ok;
        for (int m = 0; m < 16; m++) begin
            ok = m[2:0] != 3'h0 && m[2:0] != 3'h3;
            v = (m[2:0] == 3'h0) ? (m[3] ? 24'h008000 : 24'hc00000)
                                 : 24'hff0000;
            bv = !ok ? 2'h0 : m[2] ? 2'h3 : m[1] ? 2'h2 : 2'h1;
            apb(1'b1, core_cfg_pkg::OFF_OPMODE, 32'(m));
            repeat (2) @(posedge clk);
            #1 chk(reset_vector, v);
            chk(boot_variant, bv);
            apb(1'b0, core_cfg_pkg::OFF_BOOT, 32'h0);
            chk(rd, {4'h0, 1'b1, m[2:0] == 3'h3, bv, v});
            jump(ok ? 2'b10 : 2'b01);
        end
    endtask

    task automatic cfgs();
        logic [23:0] pe, de;
        logic        sc, sw, ca;
        for (int c = 0; c < 8; c++) begin
            {sc, sw, ca} = c[2:0];
            pe = sw ? (ca ? 24'h3ff : 24'h7ff) : (ca ? 24'hbff : 24'hfff);
            de = sw ? 24'hbff : 24'h7ff;
            // Cache off before the switch bit moves
            apb(1'b1, core_cfg_pkg::OFF_STATUS, 32'(sc) << 13);
            apb(1'b1, core_cfg_pkg::OFF_OPMODE, 32'(sw) << 7);
            apb(1'b1, core_cfg_pkg::OFF_STATUS,
                (32'(sc) << 13) | (32'(ca) << 19));
            apb(1'b0, core_cfg_pkg::OFF_STATUS, 32'h0);
            chk(rd, (32'(sc) << 13) | (32'(ca) << 19));
            chk({sixteen_bit_compat, memory_switch, cache_enable}, c);
            apb(1'b0, core_cfg_pkg::OFF_MAPINFO, 32'h0);
            chk(rd, {18'h0, sc, ca, 4'((de + 1) >> 10), 4'((de + 1) >> 10),
                     4'((pe + 1) >> 10)});
            look(core_cfg_pkg::SPACE_P, pe, 4'h8);
            look(core_cfg_pkg::SPACE_P, pe + 1, ca ? 4'h4 : 4'h1);
            look(core_cfg_pkg::SPACE_X, de, 4'h8);
            look(core_cfg_pkg::SPACE_Y, de + 1, 4'h1);
            look(core_cfg_pkg::SPACE_X, sc ? 24'h00ff80 : 24'hffff80,
                 4'h2);
            look(core_cfg_pkg::SPACE_P, 24'h010000, sc ? 4'h8 : 4'h1);
        end
    endtask

    initial begin
        do_reset(4'h8, 24'h008000, 2'h0);
        jump(2'b01);
        modes();
        cfgs();
        look(2'h3, 24'h000000, 4'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        do_reset(4'h6, 24'hff0000, 2'h3);
        jump(2'b10);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
